// ---- hw/vfd_pkg.sv ----
// Purpose: Shared constants and carriers for the serial display driver
// Assumes: One system clock; all pins sampled through synchronisers
// Notes:   Widths are fixed by the device architecture
package vfd_pkg;

   localparam int          STAGES     = 34;   // Shift register length
   localparam int          DRIVERS    = 33;   // Latch and driver count
   localparam int          HI_CUR     = 8;    // High-current drivers
   localparam int          LO_CUR     = 25;   // Low-current drivers
   localparam int          SYNC_DEPTH = 2;    // Flip-flops per synchroniser
   localparam logic [33:0] SHIFT_RST  = 34'h0;
   localparam logic [32:0] LATCH_RST  = 33'h0;
   localparam logic        PIN_RST    = 1'b0;
   localparam logic        BLANK_RST  = 1'b1; // Pull-up level

   // Host-side pins after synchronisation
   typedef struct packed {
      logic data;
      logic clk;
      logic load;
      logic blank_n;
   } host_pins_t;

   // Driver output split by drive class
   typedef struct packed {
      logic [HI_CUR-1:0] hi;
      logic [LO_CUR-1:0] lo;
   } drive_t;

endpackage : vfd_pkg

// ---- hw/pin_sync.sv ----
// Purpose: Two flip-flop synchroniser for one asynchronous pin
// Assumes: Destination clock is clk_sys
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_sync
   import vfd_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
)
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic pin,
   output logic      level
);

   logic meta_q;

   // Two stages to settle metastability
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         level  <= RST_VAL;
      end
      else
      begin
         meta_q <= pin;
         level  <= meta_q;
      end
   end

endmodule : pin_sync
`default_nettype wire

// ---- hw/vfd_driver.sv ----
// Purpose: Serial-in vacuum fluorescent display driver, shift and latch
// Assumes: Host pins are asynchronous and sampled at 200 MHz
// Notes:   Pin edges are found in the clk_sys domain after synchronising
//
// Summary of operation
// - The shift register holds 34 stages, stage 33 at input, 00 at output.
// - Each shift clock rise without a coincident load rise captures data into stage 33 and shifts down.
// - A load enable rise copies stages 33 to 01 into the 33-bit latch.
// - Stage 00 does not feed the latch but drives the serial data out pin.
// - The same load enable rise clears every shift stage to zero.
// - A latch one turns its driver on, a latch zero turns it off.
// - Blank low forces all drivers low, blank high lets them follow latch.
// - There are 33 driver outputs, eight high-current and 25 low-current.
// - An undriven blank input reads high as if pulled up.
`timescale 1ns/100ps
`default_nettype none
module vfd_driver
   import vfd_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic data_in,
   input  wire logic shift_clk,
   input  wire logic load_en,
   input  wire logic blank_n,
   input  wire logic blank_oe,
   output logic      data_out,
   output drive_t    drive
);

   host_pins_t       pins;
   logic             blank_pin;
   logic             clk_prev_q;
   logic             load_prev_q;
   logic             shift_rise;
   logic             load_rise;
   logic [33:0]      shift_q;
   logic [32:0]      latch_q;
   logic [32:0]      drive_d;

   // Undriven blank reads high through the pull-up
   assign blank_pin = blank_oe ? blank_n : BLANK_RST;

   // One synchroniser per host pin
   pin_sync #(.RST_VAL(PIN_RST)) u_sync_data
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin     (data_in),
      .level   (pins.data)
   );
   pin_sync #(.RST_VAL(PIN_RST)) u_sync_clk
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin     (shift_clk),
      .level   (pins.clk)
   );
   pin_sync #(.RST_VAL(PIN_RST)) u_sync_load
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin     (load_en),
      .level   (pins.load)
   );
   pin_sync #(.RST_VAL(BLANK_RST)) u_sync_blank
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin     (blank_pin),
      .level   (pins.blank_n)
   );

   // Edge history of the synchronised strobes
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         clk_prev_q  <= PIN_RST;
         load_prev_q <= PIN_RST;
      end
      else
      begin
         clk_prev_q  <= pins.clk;
         load_prev_q <= pins.load;
      end
   end

   assign shift_rise = pins.clk & ~clk_prev_q;
   assign load_rise  = pins.load & ~load_prev_q;

   // Shift chain; a load clears it and wins over a coincident shift
   // because the captured bit would be lost in the cleared register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         shift_q <= SHIFT_RST;
      else if (load_rise)
         shift_q <= SHIFT_RST;
      else if (shift_rise)
         shift_q <= {pins.data, shift_q[STAGES-1:1]};
   end

   // Latch only moves on a load rise
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         latch_q <= LATCH_RST;
      else if (load_rise)
         latch_q <= shift_q[STAGES-1:1];
   end

   // Stage 00 goes out for cascading or self-loading
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         data_out <= PIN_RST;
      else
         data_out <= shift_q[0];
   end

   // Per-driver gating by blank
   genvar g;
   generate
      for (g = 0; g < DRIVERS; g++)
      begin : g_drv
         assign drive_d[g] = latch_q[g] & pins.blank_n;
      end
   endgenerate

   // Registered outputs, high-current drivers on the top bits
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         drive <= LATCH_RST;
      else
         drive <= drive_d;
   end

   // Checks
   a_load_copies_latch:
      assert property (@(posedge clk_sys) disable iff (rst)
         load_rise |=> latch_q == $past(shift_q[33:1]))
      else $error("latch not loaded from stages 33..01");

   a_load_clears_shift:
      assert property (@(posedge clk_sys) disable iff (rst)
         load_rise |=> shift_q == 34'h0)
      else $error("shift register not cleared on load");

   a_shift_moves_down:
      assert property (@(posedge clk_sys) disable iff (rst)
         shift_rise && !load_rise |=>
            shift_q == {$past(pins.data), $past(shift_q[33:1])})
      else $error("shift step wrong");

   a_latch_holds:
      assert property (@(posedge clk_sys) disable iff (rst)
         !load_rise |=> $stable(latch_q))
      else $error("latch changed without load");

   a_data_out_tail:
      assert property (@(posedge clk_sys) disable iff (rst)
         1'b1 |=> data_out == $past(shift_q[0]))
      else $error("data out not stage 00");

   a_blank_forces_low:
      assert property (@(posedge clk_sys) disable iff (rst)
         !pins.blank_n |=> drive == 33'h0)
      else $error("drivers on while blanked");

   a_drive_follows:
      assert property (@(posedge clk_sys) disable iff (rst)
         pins.blank_n |=> drive == $past(latch_q))
      else $error("driver differs from latch");

   sequence s_float_blank;
      !blank_oe [*3];
   endsequence

   a_pullup_blank:
      assert property (@(posedge clk_sys) disable iff (rst)
         s_float_blank |-> pins.blank_n)
      else $error("floating blank not read high");

   // Pin to strobe latency: a rise sampled at one edge is seen as an
   // edge two edges later, once both synchroniser stages have passed it;
   // a slower path here would let a short self-load pulse go unseen
   sequence s_load_pin_rise;
      !load_en ##1 load_en;
   endsequence

   sequence s_clk_pin_rise;
      !shift_clk ##1 shift_clk;
   endsequence

   a_load_pin_seen:
      assert property (@(posedge clk_sys) disable iff (rst)
         s_load_pin_rise |-> ##2 load_rise)
      else $error("load pin rise not detected");

   a_clk_pin_seen:
      assert property (@(posedge clk_sys) disable iff (rst)
         s_clk_pin_rise |-> ##2 shift_rise)
      else $error("shift clock rise not detected");

   // Chain only moves on a detected strobe
   a_chain_idle_holds:
      assert property (@(posedge clk_sys) disable iff (rst)
         !shift_rise && !load_rise |=> $stable(shift_q))
      else $error("shift chain moved without a strobe");

   // High-current group sits on the top latch bits
   a_hi_group:
      assert property (@(posedge clk_sys) disable iff (rst)
         pins.blank_n |=> drive.hi == $past(latch_q[32:25]))
      else $error("high-current group differs from latch");

   // Stage 00 empties once the load has cleared the chain
   a_out_clear_after_load:
      assert property (@(posedge clk_sys) disable iff (rst)
         load_rise |-> ##2 !data_out)
      else $error("data out not cleared after load");

endmodule : vfd_driver
`default_nettype wire

// ---- verif/vfd_host.sv ----
// Purpose: Host model driving the display driver pins
// Assumes: Tasks are entered just after a clk_sys falling edge
// Notes:   Shift clock idles low between frames
`timescale 1ns/100ps
`default_nettype none
module vfd_host
(
   input  wire logic clk_sys,
   output logic      data_in,
   output logic      shift_clk,
   output logic      load_en,
   output logic      blank_n,
   output logic      blank_oe
);
   // Idle pin levels from time zero
   initial
   begin
      {data_in, shift_clk, load_en, blank_n, blank_oe} = 5'h03;
   end

   // One 80 ns shift period, data set up 20 ns ahead
   task automatic shift_bit(input logic b);
      data_in = b;
      repeat (4) @(negedge clk_sys);
      shift_clk = 1'b1;
      repeat (8) @(negedge clk_sys);
      shift_clk = 1'b0;
      data_in = ~b; // Hold over, stale value not kept
      repeat (4) @(negedge clk_sys);
   endtask : shift_bit

   // Load pulse long enough for the synchronisers
   task automatic load();
      load_en = 1'b1;
      repeat (8) @(negedge clk_sys);
      load_en = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask : load

   // Released blank shows low so a missed pull-up is seen
   task automatic set_blank(input logic oe, input logic lvl);
      blank_oe = oe;
      blank_n = lvl;
      repeat (8) @(negedge clk_sys);
   endtask : set_blank
endmodule : vfd_host
`default_nettype wire

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the serial display driver
// Assumes: Pins change on clk_sys falling edges
// Notes:   Model holds shift stages in a queue and the latch as a vector
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import vfd_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        data_in, shift_clk, load_en, blank_n, blank_oe;
   logic        data_out;
   logic        load_pin;
   logic        self_load = 1'b0;
   drive_t      drive;
   logic        sh_m[$];          // Model stages, stage 00 at the front
   logic [32:0] lat_m = LATCH_RST;
   int          fail_count = 0;
   int          comparisons = 0;
   integer      seed = 46627;

   always #2.5 clk_sys = ~clk_sys;

   // Self-loading ties data out back to load enable
   assign load_pin = self_load ? data_out : load_en;

   vfd_host u_vfd_host (.clk_sys(clk_sys), .data_in(data_in),
      .shift_clk(shift_clk), .load_en(load_en), .blank_n(blank_n),
      .blank_oe(blank_oe));
   vfd_driver u_vfd_driver (.clk_sys(clk_sys), .rst(rst),
      .data_in(data_in), .shift_clk(shift_clk), .load_en(load_pin),
      .blank_n(blank_n), .blank_oe(blank_oe), .data_out(data_out),
      .drive(drive));

   // Reference chain as a queue, stage 00 at the front
   task automatic model_clear();
      sh_m.delete();
      repeat (STAGES) sh_m.push_back(1'b0);
   endtask : model_clear

   task automatic model_shift(input logic b);
      sh_m.push_back(b);
      sh_m.delete(0);
   endtask : model_shift

   // Stages 33..01 go to the latch, then the chain empties
   task automatic model_load();
      for (int k = 0; k < DRIVERS; k++)
         lat_m[k] = sh_m[k + 1];
      model_clear();
   endtask : model_load

   // Compare pins with the model; released blank reads high
   task automatic chk(input string what);
      logic [32:0] d;
      d = (blank_oe === 1'b0 || blank_n === 1'b1) ? lat_m : 33'h0;
      comparisons++;
      if (data_out !== sh_m[0] || drive !== d)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : chk

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   // Random frames, a reset in mid-run, a short frame to see the clear,
   // and a last frame that loads itself through data out
   initial
   begin : main
      logic [33:0] v;
      int          n;
      model_clear();
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      chk("reset");
      for (int f = 0; f < 5; f++)
      begin
         v = 34'({$random(seed), $random(seed)});
         n = (f == 3) ? 5 : STAGES;
         self_load = (f == 4);
         if (self_load)
            v[0] = 1'b1; // Leading one reaches stage 00 last
         for (int i = 0; i < n; i++)
         begin
            u_vfd_host.shift_bit(v[i]);
            model_shift(v[i]);
            if (self_load && sh_m[0] === 1'b1)
               model_load();
            chk("shift");
         end
         if (!self_load)
         begin
            u_vfd_host.load();
            model_load();
            chk("load");
         end
         self_load = 1'b0;
         for (int m = 0; m < 3; m++)
         begin
            u_vfd_host.set_blank(m != 1, m == 2);
            chk("blank");
         end
         $display("frame %0d done", f);
         if (f == 1)
         begin
            rst = 1'b1;
            repeat (4) @(negedge clk_sys);
            rst = 1'b0;
            model_clear();
            lat_m = LATCH_RST;
            chk("reset again");
            $display("mid-run reset done");
         end
      end
      results();
   end

   // About 2450 cycles expected
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      results();
   end
endmodule : tb_top
`default_nettype wire
